// >>> twi_c45_slave.sv
// Two-wire serial slave carrying Clause 45 register access.
// Assumes a fast link clock that oversamples the serial pins, and a register
// file on sys_clk that answers each regReq with a one-cycle regAck.
//
// Overview of operation
// - Instruction selects header form, increment, dummy
// - Keep sixteen-bit pointer apart from data
// - Update pointer on full header or increment instruction; dummy is nacked
// - Many words under one header until stop
// - Half-written word dropped, no increment
// - Half-read word lost, no increment
// - Write with no data: no increment
// - Ack first byte on address and top 10
// - Ack second byte: supported selector, instruction bit2 zero
// - Ack write data only after clean header
// - Ack pointer bytes only with full header
// - Drive read data only after clean header
// - Stop or nack aborts word, ignore bus
// - Lone first pointer byte leaves pointer unchanged
// - Early start aborts word, begins new transaction
// - Pointer wraps from top value to zero
// - Two header bytes: address, selector, direction, instruction
// - Stop cancels operation, return to standby
`timescale 1ns/1ps
`include "twi_c45_params.svh"

module twi_c45_slave (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        linkClk,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output      logic        sdaOut,
	output      logic        sdaOeN,
	input  wire logic [4:0]  portAddrStrap,
	output      logic        regReq,
	output      logic        regWrite,
	output      logic [4:0]  regDevice,
	output      logic [15:0] regAddr,
	output      logic [15:0] regWdata,
	input  wire logic        regAck,
	input  wire logic [15:0] regRdata
);

	localparam logic [31:0] DEV_SUPPORT = `TW_DEV_SUPPORT;

	twi_c45_pkg::link_t link_reg;
	twi_c45_pkg::link_t link_next;
	twi_c45_pkg::sys_t  sys_reg;
	twi_c45_pkg::sys_t  sys_next;

	logic        sclS;
	logic        sdaS;
	logic [4:0]  strapS;
	logic        ackSync;
	logic        reqSync;
	logic        startEv;
	logic        stopEv;
	logic        sclRise;
	logic        sclFall;
	logic        busy;
	logic        accept;
	logic        hdr1Ok;
	logic        devOk;
	logic        fullHdr;
	logic        postInc;
	logic        ptrLoad;
	logic [15:0] ptrLoadVal;
	logic        ptrInc;
	logic [15:0] ptr;
	logic [15:0] ptrPlusOne;
	logic [7:0]  curByte;

	// ==========================================
	// Crossings
	sync_2ff #(.W(7)) u_pinSync (
		.clk    (linkClk),
		.arst_n (arst_n),
		.d      ({portAddrStrap, sclIn, sdaIn}),
		.q      ({strapS, sclS, sdaS})
	);

	sync_2ff #(.W(1)) u_ackSync (
		.clk    (linkClk),
		.arst_n (arst_n),
		.d      (sys_reg.ackTgl),
		.q      (ackSync)
	);

	sync_2ff #(.W(1)) u_reqSync (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.d      (link_reg.reqTgl),
		.q      (reqSync)
	);

	pointer_store u_ptr (
		.clk        (linkClk),
		.arst_n     (arst_n),
		.load       (ptrLoad),
		.loadValue  (ptrLoadVal),
		.increment  (ptrInc),
		.ptr        (ptr),
		.ptrPlusOne (ptrPlusOne)
	);

	// ==========================================
	// Link events and decodes
	assign startEv = sclS && link_reg.sclPrev && link_reg.sdaPrev && !sdaS;
	assign stopEv  = sclS && link_reg.sclPrev && !link_reg.sdaPrev && sdaS;
	assign sclRise = sclS && !link_reg.sclPrev;
	assign sclFall = !sclS && link_reg.sclPrev;
	assign busy    = link_reg.reqTgl != ackSync;

	// First byte: 1, 0, port address, direction
	assign hdr1Ok = link_reg.strapDone && (link_reg.shift[7:6] == `TW_HDR_TOP)
		&& (link_reg.shift[5:1] == link_reg.portAddr);
	// Second byte: selector, instruction
	assign devOk = DEV_SUPPORT[link_reg.shift[7:3]] && !link_reg.shift[2];

	assign fullHdr = (link_reg.instr == twi_c45_pkg::INSTR_FULL_KEEP)
		|| (link_reg.instr == twi_c45_pkg::INSTR_FULL_INC);
	assign postInc = (link_reg.instr == twi_c45_pkg::INSTR_STORED_INC)
		|| (link_reg.instr == twi_c45_pkg::INSTR_FULL_INC);

	// Outgoing word leaves high byte first
	assign curByte = link_reg.half ? sys_reg.rdata[7:0] : sys_reg.rdata[15:8];

	always_comb begin
		case (link_reg.byteIdx)
			`TW_BYTE_HDR1:  accept = hdr1Ok;
			`TW_BYTE_HDR2:  accept = devOk;
			`TW_BYTE_PTRHI: accept = 1'b1;
			`TW_BYTE_PTRLO: accept = 1'b1;
			default:        accept = !link_reg.isRead;
		endcase
	end

	// Hands a word request to the system side; bundle holds until answered
	function automatic twi_c45_pkg::link_t issue(
		input twi_c45_pkg::link_t s,
		input logic               wr,
		input logic [15:0]        addr,
		input logic [15:0]        data,
		input logic [4:0]         dev
	);
		twi_c45_pkg::link_t r;
		r          = s;
		r.reqTgl   = ~s.reqTgl;
		r.reqWrite = wr;
		r.reqAddr  = addr;
		r.reqData  = data;
		r.reqDev   = dev;
		return r;
	endfunction : issue

	// ==========================================
	// Link engine
	always_comb begin
		link_next         = link_reg;
		ptrLoad           = 1'b0;
		ptrLoadVal        = `TW_PTR_ZERO;
		ptrInc            = 1'b0;
		link_next.sclPrev = sclS;
		link_next.sdaPrev = sdaS;
		if (!link_reg.strapDone) begin
			link_next.strapCnt = 2'(link_reg.strapCnt + 2'h1);
			if (link_reg.strapCnt == `TW_STRAP_WAIT) begin
				link_next.portAddr  = strapS;
				link_next.strapDone = 1'b1;
			end
		end
		if (startEv) begin
			// Any unfinished word is simply never committed
			link_next.state   = twi_c45_pkg::ST_RECV;
			link_next.byteIdx = `TW_BYTE_HDR1;
			link_next.bitCnt  = 4'h0;
			link_next.half    = 1'b0;
			link_next.drvN    = 1'b1;
		end else if (stopEv) begin
			link_next.state = twi_c45_pkg::ST_IGNORE;
			link_next.drvN  = 1'b1;
		end else begin
			case (link_reg.state)
				twi_c45_pkg::ST_RECV: begin
					if (sclRise) begin
						link_next.shift  = {link_reg.shift[6:0], sdaS};
						link_next.bitCnt = 4'(link_reg.bitCnt + 4'h1);
					end else if (sclFall && link_reg.bitCnt == `TW_BITS_PER_BYTE) begin
						link_next.bitCnt = 4'h0;
						if (!accept) begin
							link_next.state = twi_c45_pkg::ST_IGNORE;
						end else begin
							link_next.state = twi_c45_pkg::ST_ACK;
							link_next.drvN  = 1'b0;
							case (link_reg.byteIdx)
								`TW_BYTE_HDR1: begin
									link_next.isRead  = link_reg.shift[0];
									link_next.byteIdx = `TW_BYTE_HDR2;
								end
								`TW_BYTE_HDR2: begin
									link_next.instr  = link_reg.shift[2:0];
									link_next.devSel = link_reg.shift[7:3];
									link_next.half   = 1'b0;
									if (link_reg.shift[1]) begin
										link_next.byteIdx = `TW_BYTE_PTRHI;
									end else begin
										link_next.byteIdx = `TW_BYTE_DATA;
										if (link_reg.isRead) begin
											link_next = issue(link_next, 1'b0, ptr,
												`TW_PTR_ZERO, link_reg.shift[7:3]);
										end
									end
								end
								`TW_BYTE_PTRHI: begin
									link_next.ptrHi   = link_reg.shift;
									link_next.byteIdx = `TW_BYTE_PTRLO;
								end
								`TW_BYTE_PTRLO: begin
									// Pointer is loaded only once both bytes are in
									ptrLoad           = 1'b1;
									ptrLoadVal        = {link_reg.ptrHi, link_reg.shift};
									link_next.byteIdx = `TW_BYTE_DATA;
									if (link_reg.isRead) begin
										link_next = issue(link_next, 1'b0, ptrLoadVal,
											`TW_PTR_ZERO, link_reg.devSel);
									end
								end
								default: begin
									if (!link_reg.half) begin
										link_next.dataHi = link_reg.shift;
										link_next.half   = 1'b1;
									end else begin
										// Whole word in: commit, then step the pointer if the instruction increments
										link_next.half = 1'b0;
										link_next = issue(link_next, 1'b1, ptr,
											{link_reg.dataHi, link_reg.shift}, link_reg.devSel);
										ptrInc = postInc;
									end
								end
							endcase
						end
					end
				end
				twi_c45_pkg::ST_ACK: begin
					if (sclFall) begin
						link_next.drvN = 1'b1;
						if (link_reg.isRead && link_reg.byteIdx == `TW_BYTE_DATA) begin
							link_next.state    = twi_c45_pkg::ST_SEND;
							link_next.loadPend = 1'b1;
						end else begin
							link_next.state = twi_c45_pkg::ST_RECV;
						end
					end
				end
				twi_c45_pkg::ST_SEND: begin
					if (sclRise) begin
						link_next.bitCnt = 4'(link_reg.bitCnt + 4'h1);
					end else if (sclFall) begin
						if (link_reg.bitCnt == `TW_BITS_PER_BYTE) begin
							link_next.drvN   = 1'b1;
							link_next.bitCnt = 4'h0;
							link_next.state  = twi_c45_pkg::ST_MACK;
						end else begin
							link_next.loadPend = 1'b1;
						end
					end else if (link_reg.loadPend && !busy) begin
						// Data bit is put out only once the word has arrived
						link_next.drvN     = curByte[3'(3'h7 - link_reg.bitCnt[2:0])];
						link_next.loadPend = 1'b0;
					end
				end
				twi_c45_pkg::ST_MACK: begin
					if (sclRise) begin
						if (sdaS) begin
							// Nack after a full word still counts the word
							link_next.state = twi_c45_pkg::ST_IGNORE;
							ptrInc          = link_reg.half && postInc;
						end else if (!link_reg.half) begin
							link_next.half  = 1'b1;
							link_next.state = twi_c45_pkg::ST_SEND;
						end else begin
							link_next.half  = 1'b0;
							link_next.state = twi_c45_pkg::ST_SEND;
							ptrInc          = postInc;
							link_next = issue(link_next, 1'b0, postInc ? ptrPlusOne : ptr,
								`TW_PTR_ZERO, link_reg.devSel);
						end
					end
				end
				twi_c45_pkg::ST_IGNORE: begin
					link_next.drvN = 1'b1;
				end
				default: begin
					link_next.state = twi_c45_pkg::ST_IGNORE;
				end
			endcase
		end
	end

	always_ff @(posedge linkClk or negedge arst_n) begin
		if (!arst_n) begin
			link_reg      <= '0;
			link_reg.drvN <= 1'b1;
		end else begin
			link_reg <= link_next;
		end
	end

	// ==========================================
	// System side request port
	always_comb begin
		sys_next = sys_reg;
		if (!sys_reg.regReq && reqSync != sys_reg.reqSeen) begin
			sys_next.reqSeen  = reqSync;
			sys_next.regReq   = 1'b1;
			sys_next.regWrite = link_reg.reqWrite;
			sys_next.regDev   = link_reg.reqDev;
			sys_next.regAddr  = link_reg.reqAddr;
			sys_next.regWdata = link_reg.reqData;
		end else if (sys_reg.regReq && regAck) begin
			sys_next.regReq = 1'b0;
			sys_next.ackTgl = ~sys_reg.ackTgl;
			if (!sys_reg.regWrite) begin
				sys_next.rdata = regRdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sys_reg <= '0;
		end else begin
			sys_reg <= sys_next;
		end
	end

	assign sdaOut    = link_reg.sdaLevel;
	assign sdaOeN    = link_reg.drvN;
	assign regReq    = sys_reg.regReq;
	assign regWrite  = sys_reg.regWrite;
	assign regDevice = sys_reg.regDev;
	assign regAddr   = sys_reg.regAddr;
	assign regWdata  = sys_reg.regWdata;

	// ==========================================
	// Checks
	AST_HDR1_NACK: assert property (@(posedge linkClk) disable iff (!arst_n)
		(link_reg.state == twi_c45_pkg::ST_RECV && sclFall && !startEv && !stopEv
		&& link_reg.bitCnt == `TW_BITS_PER_BYTE && link_reg.byteIdx == `TW_BYTE_HDR1
		&& !hdr1Ok) |=> link_reg.drvN && link_reg.state == twi_c45_pkg::ST_IGNORE)
		else $error("First byte acknowledged without address match");

	AST_HDR1_ACK: assert property (@(posedge linkClk) disable iff (!arst_n)
		(link_reg.state == twi_c45_pkg::ST_RECV && sclFall && !startEv && !stopEv
		&& link_reg.bitCnt == `TW_BITS_PER_BYTE && link_reg.byteIdx == `TW_BYTE_HDR1
		&& hdr1Ok) |=> !link_reg.drvN && link_reg.byteIdx == `TW_BYTE_HDR2)
		else $error("Matching first byte not acknowledged");

	AST_HDR2_RSV: assert property (@(posedge linkClk) disable iff (!arst_n)
		(link_reg.state == twi_c45_pkg::ST_RECV && sclFall && !startEv && !stopEv
		&& link_reg.bitCnt == `TW_BITS_PER_BYTE && link_reg.byteIdx == `TW_BYTE_HDR2
		&& link_reg.shift[2]) |=> link_reg.state == twi_c45_pkg::ST_IGNORE)
		else $error("Reserved instruction acknowledged");

	AST_READ_NO_WDATA: assert property (@(posedge linkClk) disable iff (!arst_n)
		(link_reg.isRead && link_reg.byteIdx == `TW_BYTE_DATA
		&& link_reg.state != twi_c45_pkg::ST_SEND
		&& link_reg.state != twi_c45_pkg::ST_ACK) |-> link_reg.drvN)
		else $error("Data byte acknowledged in a read");

	AST_STOP_IDLE: assert property (@(posedge linkClk) disable iff (!arst_n)
		(stopEv && !startEv) |=> link_reg.state == twi_c45_pkg::ST_IGNORE
		&& link_reg.drvN [*2])
		else $error("Stop did not return to standby");

	AST_START_NEW: assert property (@(posedge linkClk) disable iff (!arst_n)
		startEv |=> link_reg.state == twi_c45_pkg::ST_RECV
		&& link_reg.byteIdx == `TW_BYTE_HDR1 && link_reg.bitCnt == 4'h0 && !link_reg.half)
		else $error("Start did not begin a new transaction");

	AST_PTR_LOAD: assert property (@(posedge linkClk) disable iff (!arst_n)
		ptrLoad |=> ptr == $past(ptrLoadVal))
		else $error("Pointer not loaded from header");

	AST_WRITE_WHOLE: assert property (@(posedge linkClk) disable iff (!arst_n)
		($changed(link_reg.reqTgl) && link_reg.reqWrite) |-> $past(link_reg.half)
		&& !link_reg.half)
		else $error("Write issued for a partial word");

	AST_SEND_WAITS: assert property (@(posedge linkClk) disable iff (!arst_n)
		(link_reg.state == twi_c45_pkg::ST_SEND && link_reg.loadPend && busy
		&& !sclRise && !sclFall && !startEv && !stopEv) |=> $stable(link_reg.drvN))
		else $error("Read data driven before it arrived");

	AST_REQ_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(regReq && !regAck) |=> regReq && $stable(regAddr) && $stable(regWdata))
		else $error("Register request dropped before answer");

endmodule : twi_c45_slave

// >>> twi_c45_params.svh
// Constants of the two-wire Clause 45 register access slave.
// Assumes inclusion by bare name wherever the block's modules need them.
`ifndef TWI_C45_PARAMS_SVH
`define TWI_C45_PARAMS_SVH

// ==========================================
// Header byte fields
`define TW_HDR_TOP        2'h2
`define TW_DEV_SUPPORT    32'hc000_008a
`define TW_BITS_PER_BYTE  4'h8

// ==========================================
// Byte positions within a transaction
`define TW_BYTE_HDR1      3'h0
`define TW_BYTE_HDR2      3'h1
`define TW_BYTE_PTRHI     3'h2
`define TW_BYTE_PTRLO     3'h3
`define TW_BYTE_DATA      3'h4

// ==========================================
// Reset values and limits
`define TW_PTR_ZERO       16'h0000
`define TW_PTR_MAX        16'hffff
`define TW_PTR_ONE        16'h0001
`define TW_STRAP_WAIT     2'h3

`endif

// >>> twi_c45_pkg.sv
// Types of the two-wire Clause 45 register access slave.
// Assumes the constants header is compiled alongside.
package twi_c45_pkg;

	// ==========================================
	// Instruction codes
	typedef enum logic [2:0] {
		INSTR_STORED_KEEP,
		INSTR_STORED_INC,
		INSTR_FULL_KEEP,
		INSTR_FULL_INC,
		INSTR_DUMMY,
		INSTR_RSV5,
		INSTR_RSV6,
		INSTR_RSV7
	} instr_t;

	// ==========================================
	// Link engine states
	typedef enum logic [2:0] {
		ST_IGNORE,
		ST_RECV,
		ST_ACK,
		ST_SEND,
		ST_MACK
	} link_state_t;

	typedef struct packed {
		link_state_t state;
		logic        sclPrev;
		logic        sdaPrev;
		logic [3:0]  bitCnt;
		logic [7:0]  shift;
		logic [2:0]  byteIdx;
		logic        isRead;
		logic [2:0]  instr;
		logic [4:0]  devSel;
		logic [7:0]  ptrHi;
		logic [7:0]  dataHi;
		logic        half;
		logic        loadPend;
		logic        drvN;
		logic        sdaLevel;
		logic        reqTgl;
		logic        reqWrite;
		logic [15:0] reqAddr;
		logic [15:0] reqData;
		logic [4:0]  reqDev;
		logic [4:0]  portAddr;
		logic [1:0]  strapCnt;
		logic        strapDone;
	} link_t;

	typedef struct packed {
		logic        reqSeen;
		logic        ackTgl;
		logic        regReq;
		logic        regWrite;
		logic [4:0]  regDev;
		logic [15:0] regAddr;
		logic [15:0] regWdata;
		logic [15:0] rdata;
	} sys_t;

endpackage : twi_c45_pkg

// >>> sync_2ff.sv
// Two flip-flop synchroniser for levels and toggles.
// Assumes its input is a level that holds for several destination clocks.
`timescale 1ns/1ps

module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t sync_reg;
	sync_t sync_next;

	always_comb begin
		sync_next    = sync_reg;
		sync_next.s1 = d;
		sync_next.s2 = sync_reg.s1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign q = sync_reg.s2;

endmodule : sync_2ff

// >>> pointer_store.sv
// Stored register pointer with load and wrapping post-increment.
// Assumes load and increment come from logic on the same clock.
`timescale 1ns/1ps
`include "twi_c45_params.svh"

module pointer_store (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        load,
	input  wire logic [15:0] loadValue,
	input  wire logic        increment,
	output      logic [15:0] ptr,
	output      logic [15:0] ptrPlusOne
);

	typedef struct packed {
		logic [15:0] ptr;
	} ptr_t;

	ptr_t ptr_reg;
	ptr_t ptr_next;

	// Rolls over from the top value back to zero
	assign ptrPlusOne = (ptr_reg.ptr == `TW_PTR_MAX) ? `TW_PTR_ZERO
		: 16'(ptr_reg.ptr + `TW_PTR_ONE);

	always_comb begin
		ptr_next = ptr_reg;
		if (load) begin
			ptr_next.ptr = loadValue;
		end else if (increment) begin
			ptr_next.ptr = ptrPlusOne;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_reg <= '0;
		end else begin
			ptr_reg <= ptr_next;
		end
	end

	assign ptr = ptr_reg.ptr;

	AST_PTR_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
		(increment && !load && ptr_reg.ptr == `TW_PTR_MAX) |=> ptr_reg.ptr == `TW_PTR_ZERO)
		else $error("Pointer did not wrap to zero");

	AST_PTR_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		(!increment && !load) |=> $stable(ptr_reg.ptr))
		else $error("Pointer moved without load or increment");

endmodule : pointer_store

// >>> two_wire_master.sv
// Behavioural bus master driving the serial clock and data wire.
// Assumes a pull-up on the data wire; the clock stands high between frames.
`timescale 1ns/1ps

module two_wire_master #(
	parameter int QTR = 1000
) (
	output logic      sclPin,
	output logic      sdaRel,
	input  wire logic sdaWire
);
	initial begin
		sclPin = 1'b1;
		sdaRel = 1'b1;
	end

	// Data changes only while the clock is low
	task automatic bitx(input logic b, output logic s);
		sdaRel = b;
		#QTR sclPin = 1'b1;
		#QTR s = sdaWire;
		#QTR sclPin = 1'b0;
		#QTR;
	endtask : bitx

	task automatic start_cond();
		sdaRel = 1'b1;
		#QTR sclPin = 1'b1;
		#QTR sdaRel = 1'b0;
		#QTR sclPin = 1'b0;
		#QTR;
	endtask : start_cond

	task automatic stop_cond();
		sdaRel = 1'b0;
		#QTR sclPin = 1'b1;
		#QTR sdaRel = 1'b1;
		#QTR;
	endtask : stop_cond

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(b[i], s);
		bitx(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, s);
			b[i] = s;
		end
		bitx(nack, s);
	endtask : recv_byte
endmodule : two_wire_master

// >>> two_wire_clause45_register_access_tb.sv
// Self-checking bench of the two-wire register access slave.
// Assumes the master model beside it; the bench answers as register file.
`timescale 1ns/1ps
`include "twi_c45_params.svh"

module two_wire_clause45_register_access_tb;
	localparam logic [4:0] PORT = 5'h13;
	localparam logic [4:0] SEL  = 5'h03;
	logic        sys_clk, linkClk, arst_n, sclPin, sdaRel, sdaOut, sdaOeN;
	logic        regReq, regWrite, regAck, lastWrite;
	logic [4:0]  regDevice, lastDev;
	logic [15:0] regAddr, regWdata, regRdata, lastAddr, lastData;
	int          reqCount, expCount, waitCnt, err_count, num_checks;
	wire         sdaWire = sdaRel & (sdaOeN | sdaOut);

	twi_c45_slave twi_c45_slave_inst (.sys_clk(sys_clk), .arst_n(arst_n), .linkClk(linkClk),
		.sclIn(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
		.portAddrStrap(PORT), .regReq(regReq), .regWrite(regWrite), .regDevice(regDevice),
		.regAddr(regAddr), .regWdata(regWdata), .regAck(regAck), .regRdata(regRdata));
	two_wire_master #(.QTR(250)) two_wire_master_inst (.sclPin(sclPin), .sdaRel(sdaRel),
		.sdaWire(sdaWire));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		linkClk = 1'b0;
		#3.7;
		forever #6 linkClk = ~linkClk;
	end

	function automatic logic [15:0] rd_fn(input logic [15:0] a);
		return a ^ 16'hc35a;
	endfunction : rd_fn

	// ==========================================
	// Register file: acknowledges each request on its third cycle
	always @(posedge sys_clk) begin
		#1;
		if (regReq === 1'b1 && !regAck && waitCnt == 2) begin
			regAck = 1'b1;
			regRdata = rd_fn(regAddr);
			{lastWrite, lastAddr, lastData, lastDev} = {regWrite, regAddr, regWdata, regDevice};
			reqCount++;
			waitCnt = 0;
		end else begin
			waitCnt = (regReq === 1'b1 && !regAck) ? waitCnt + 1 : 0;
			regAck = 1'b0;
		end
	end

	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// ==========================================
	// Transfer helpers
	task automatic wait_req();
		expCount++;
		for (int i = 0; i < 400 && reqCount < expCount; i++) @(posedge sys_clk);
		chk16(16'(reqCount), 16'(expCount));
	endtask : wait_req

	task automatic hdr(input logic rd, input logic [2:0] instr);
		logic a;
		two_wire_master_inst.start_cond();
		two_wire_master_inst.send_byte({`TW_HDR_TOP, PORT, rd}, a);
		chk1(a, 1'b1);
		two_wire_master_inst.send_byte({SEL, instr}, a);
		chk1(a, 1'b1);
	endtask : hdr

	task automatic ptrb(input logic [15:0] p);
		logic a;
		two_wire_master_inst.send_byte(p[15:8], a);
		chk1(a, 1'b1);
		two_wire_master_inst.send_byte(p[7:0], a);
		chk1(a, 1'b1);
	endtask : ptrb

	task automatic wrw(input logic [15:0] w, input logic [15:0] ea);
		logic a;
		two_wire_master_inst.send_byte(w[15:8], a);
		chk1(a, 1'b1);
		two_wire_master_inst.send_byte(w[7:0], a);
		chk1(a, 1'b1);
		wait_req();
		chk16(lastAddr, ea);
		chk16(lastData, w);
		chk1(lastWrite, 1'b1);
		chk16(16'(lastDev), 16'(SEL));
	endtask : wrw

	task automatic rdw(input logic [15:0] ea, input logic last);
		logic [7:0] h, l;
		wait_req();
		chk16(lastAddr, ea);
		chk1(lastWrite, 1'b0);
		chk16(16'(lastDev), 16'(SEL));
		two_wire_master_inst.recv_byte(1'b0, h);
		two_wire_master_inst.recv_byte(last, l);
		chk16({h, l}, rd_fn(ea));
	endtask : rdw

	// ==========================================
	// Scenarios
	task automatic t_wrap();
		hdr(1'b0, 3'h3);
		ptrb(16'hfffe);
		wrw(16'h1111, 16'hfffe);
		wrw(16'h2222, 16'hffff);
		two_wire_master_inst.stop_cond();
		hdr(1'b1, 3'h0);
		rdw(16'h0000, 1'b1);
		two_wire_master_inst.stop_cond();
		hdr(1'b1, 3'h1);
		rdw(16'h0000, 1'b0);
		rdw(16'h0001, 1'b1);
		two_wire_master_inst.stop_cond();
		hdr(1'b0, 3'h2);
		ptrb(16'h0010);
		wrw(16'h2b2b, 16'h0010);
		wrw(16'h2c2c, 16'h0010);
		two_wire_master_inst.stop_cond();
		hdr(1'b1, 3'h3);
		ptrb(16'h0040);
		rdw(16'h0040, 1'b1);
		two_wire_master_inst.stop_cond();
		hdr(1'b1, 3'h0);
		rdw(16'h0041, 1'b1);
		two_wire_master_inst.stop_cond();
	endtask : t_wrap

	task automatic t_refuse();
		logic       a;
		logic [7:0] b1 [7] = '{{2'h3, PORT, 1'b0}, {2'h2, PORT ^ 5'h01, 1'b0},
			{2'h2, PORT, 1'b0}, {2'h2, PORT, 1'b0}, {2'h2, PORT, 1'b0}, {2'h2, PORT, 1'b0},
			{2'h2, PORT, 1'b1}};
		logic [7:0] b2 [7] = '{8'h00, 8'h00, {5'h02, 3'h2}, {SEL, 3'h4}, {SEL, 3'h5},
			{SEL, 3'h6}, {SEL, 3'h7}};
		for (int i = 0; i < 7; i++) begin
			two_wire_master_inst.start_cond();
			two_wire_master_inst.send_byte(b1[i], a);
			chk1(a, i >= 2);
			if (i >= 2) begin
				two_wire_master_inst.send_byte(b2[i], a);
				chk1(a, 1'b0);
			end
			two_wire_master_inst.send_byte(8'h00, a);
			chk1(a, 1'b0);
			two_wire_master_inst.stop_cond();
		end
	endtask : t_refuse

	task automatic t_partial();
		logic a;
		hdr(1'b0, 3'h3);
		ptrb(16'h0100);
		two_wire_master_inst.send_byte(8'h99, a);
		chk1(a, 1'b1);
		two_wire_master_inst.stop_cond();
		hdr(1'b0, 3'h0);
		wrw(16'h3333, 16'h0100);
		two_wire_master_inst.stop_cond();
		hdr(1'b0, 3'h3);
		ptrb(16'h0200);
		two_wire_master_inst.stop_cond();
		hdr(1'b0, 3'h0);
		wrw(16'h4444, 16'h0200);
		two_wire_master_inst.stop_cond();
		hdr(1'b0, 3'h3);
		two_wire_master_inst.send_byte(8'h55, a);
		chk1(a, 1'b1);
		two_wire_master_inst.stop_cond();
		hdr(1'b0, 3'h0);
		wrw(16'h5555, 16'h0200);
		two_wire_master_inst.stop_cond();
	endtask : t_partial

	task automatic t_abort();
		logic       a;
		logic [7:0] h;
		hdr(1'b0, 3'h3);
		ptrb(16'h0300);
		two_wire_master_inst.send_byte(8'h77, a);
		chk1(a, 1'b1);
		hdr(1'b0, 3'h0);
		wrw(16'h6666, 16'h0300);
		two_wire_master_inst.stop_cond();
		hdr(1'b1, 3'h1);
		wait_req();
		chk16(lastAddr, 16'h0300);
		two_wire_master_inst.recv_byte(1'b1, h);
		chk16({8'h00, h}, {8'h00, 8'hc3 ^ 8'h03});
		two_wire_master_inst.stop_cond();
		hdr(1'b1, 3'h0);
		rdw(16'h0300, 1'b1);
		two_wire_master_inst.stop_cond();
	endtask : t_abort

	initial begin
		{arst_n, regAck, regRdata, lastWrite, lastAddr, lastData, lastDev} = '0;
		{reqCount, expCount, waitCnt, err_count, num_checks} = '0;
		repeat (12) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		repeat (20) @(posedge sys_clk);
		t_wrap();
		t_refuse();
		t_partial();
		t_abort();
		wrap_up();
	end

	initial begin
		#2_000_000;
		err_count++;
		wrap_up();
	end
endmodule : two_wire_clause45_register_access_tb
